// File: usam_core.v
`timescale 1ns/1ps
`include "usam_map.vh"
module usam_core (
  input wire ref_clk,
  input wire reset,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire timer1_overflow,
  output reg shift_clock_line,
  input wire shift_data_line_in,
  output reg shift_data_line_out,
  output reg shift_data_line_oe
);

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  localparam TX_IDLE = 4'h1;
  localparam TX_ARM = 4'h2;
  localparam TX_SEND = 4'h4;
  localparam TX_DATA = 4'h8;
  localparam RX_IDLE = 4'h1;
  localparam RX_ARM = 4'h2;
  localparam RX_RECV = 4'h4;
  localparam RX_ASYNC = 4'h8;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One-hot register select: bit0 data, bit1 control, bit2 power
  function [2:0] reg_select;
    input [11:0] addr;
    begin
      reg_select = 3'h0;
      if (addr == `USAM_ADDR_DATA) begin
        reg_select = 3'h1;
      end else if (addr == `USAM_ADDR_CTRL) begin
        reg_select = 3'h2;
      end else if (addr == `USAM_ADDR_POWER) begin
        reg_select = 3'h4;
      end
    end
  endfunction

  // Both receivers shift left, so the first bit lands on top
  function [7:0] bit_reverse;
    input [7:0] value;
    integer i;
    begin
      bit_reverse = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        bit_reverse[i] = value[7 - i];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [2:0] mstate;
  reg data_meta;
  reg data_sync;
  reg data_prev;
  reg ovf_half;
  reg [3:0] div16;
  reg [7:0] rx_buffer;
  reg rx_done_flag;
  reg tx_done_flag;
  reg rx_ninth_bit;
  reg rx_enable;
  reg multiproc_qualify_bit;
  reg mode_async;
  reg baud_double_bit;
  reg [3:0] tx_state;
  reg [8:0] tx_sr;
  reg tx_cyc;
  reg tx_roll;
  reg tx_last;
  reg [3:0] rx_state;
  reg [8:0] rx_sr;
  reg rx_first;
  reg rx_last;
  reg rx_sample;
  reg [2:0] votes;
  reg tx_set;
  reg rx_set;
  reg next_clock;
  reg next_data_out;
  reg next_data_oe;
  reg [31:0] next_prdata;
  wire [2:0] sel;
  wire apb_req;
  wire wr_fire;
  wire wr_data;
  wire wr_ctrl;
  wire wr_power;
  wire at_s1;
  wire at_s6;
  wire tick16;
  wire rollover;
  wire fall;
  wire rx_start;
  wire vote_bit;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Writes land on the edge where the master sees pready high
  assign sel = reg_select(paddr);
  assign apb_req = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign wr_data = wr_fire & sel[0];
  assign wr_ctrl = wr_fire & sel[1];
  assign wr_power = wr_fire & sel[2];

  // ----------------------------------------------------------------
  // Timing base
  // ----------------------------------------------------------------
  // Six states per machine cycle, one clock each
  always @(posedge ref_clk) begin
    if (reset) begin
      mstate <= `USAM_ST_S1;
    end else if (mstate == `USAM_ST_S6) begin
      mstate <= `USAM_ST_S1;
    end else begin
      mstate <= mstate + 3'h1;
    end
  end

  assign at_s1 = (mstate == `USAM_ST_S1);
  assign at_s6 = (mstate == `USAM_ST_S6);

  // Halve the overflows unless the doubling bit is set
  assign tick16 = timer1_overflow &
                  (baud_double_bit | ovf_half);
  assign rollover = tick16 & (div16 == `USAM_DIV_LAST);
  assign fall = data_prev & ~data_sync;
  assign rx_start = (rx_state == RX_IDLE) & mode_async & rx_enable & fall;

  // Overflow halver and divide-by-16 counter
  always @(posedge ref_clk) begin
    if (reset) begin
      ovf_half <= 1'b0;
      div16 <= 4'h0;
    end else begin
      if (timer1_overflow) begin
        ovf_half <= ~ovf_half;
      end
      if (rx_start) begin
        div16 <= 4'h0;
      end else if (tick16) begin
        div16 <= div16 + 4'h1;
      end
    end
  end

  // Data pin is asynchronous; the edge finder reads only stages two and three
  always @(posedge ref_clk) begin
    if (reset) begin
      data_meta <= 1'b1;
      data_sync <= 1'b1;
      data_prev <= 1'b1;
    end else begin
      data_meta <= shift_data_line_in;
      data_sync <= data_meta;
      data_prev <= data_sync;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Flags: writing 0 clears, hardware set wins over that clear
  always @(posedge ref_clk) begin
    if (reset) begin
      rx_done_flag <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_enable <= 1'b0;
      multiproc_qualify_bit <= 1'b0;
      mode_async <= 1'b0;
      baud_double_bit <= `USAM_BAUD_DOUBLE_RST;
    end else begin
      if (rx_set) begin
        rx_done_flag <= 1'b1;
      end else if (wr_ctrl & ~pwdata[`USAM_CTRL_RX_DONE]) begin
        rx_done_flag <= 1'b0;
      end
      if (tx_set) begin
        tx_done_flag <= 1'b1;
      end else if (wr_ctrl & ~pwdata[`USAM_CTRL_TX_DONE]) begin
        tx_done_flag <= 1'b0;
      end
      if (wr_ctrl) begin
        rx_enable <= pwdata[`USAM_CTRL_RX_EN];
        multiproc_qualify_bit <= pwdata[`USAM_CTRL_QUALIFY];
        mode_async <= pwdata[`USAM_CTRL_ASYNC];
      end
      if (wr_power) begin
        baud_double_bit <= pwdata[`USAM_POWER_DOUBLE];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    next_prdata = 32'h00000000;
    if (sel[0]) begin
      next_prdata[7:0] = rx_buffer;
    end else if (sel[1]) begin
      next_prdata[`USAM_CTRL_RX_DONE] = rx_done_flag;
      next_prdata[`USAM_CTRL_TX_DONE] = tx_done_flag;
      next_prdata[`USAM_CTRL_NINTH] = rx_ninth_bit;
      next_prdata[`USAM_CTRL_RX_EN] = rx_enable;
      next_prdata[`USAM_CTRL_QUALIFY] = multiproc_qualify_bit;
      next_prdata[`USAM_CTRL_ASYNC] = mode_async;
    end else if (sel[2]) begin
      next_prdata[`USAM_POWER_DOUBLE] = baud_double_bit;
    end
  end

  // One wait state, so every answer comes from a flip-flop
  always @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_req;
      if (apb_req) begin
        pslverr <= ~(|sel);
        prdata <= pwrite ? 32'h00000000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // A write while busy is dropped, the frame in flight is kept
  always @(posedge ref_clk) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      tx_sr <= 9'h1FF;
      tx_cyc <= 1'b0;
      tx_roll <= 1'b0;
      tx_last <= 1'b0;
      tx_set <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (wr_data) begin
            tx_sr <= {`USAM_TX_LOAD, pwdata[7:0]};
            tx_cyc <= 1'b0;
            tx_roll <= 1'b0;
            tx_last <= 1'b0;
            tx_state <= TX_ARM;
          end
        end
        TX_ARM: begin
          if (!mode_async) begin
            // First S6 is the write's own cycle, second starts send
            if (at_s6) begin
              if (tx_cyc) begin
                tx_state <= TX_SEND;
              end else begin
                tx_cyc <= 1'b1;
              end
            end
          end else begin
            if (rollover) begin
              tx_roll <= 1'b1;
            end
            if (tx_roll & at_s1) begin
              tx_state <= TX_SEND;
            end
          end
        end
        TX_SEND: begin
          if (!mode_async) begin
            if (tx_last & at_s1) begin
              tx_state <= TX_IDLE;
              tx_set <= 1'b1;
            end else if (at_s6 & !tx_last) begin
              tx_sr <= {1'b0, tx_sr[8:1]};
              // Marker test ignores the LSB now at the output
              if (tx_sr[8:1] == `USAM_TX_MARK) begin
                tx_last <= 1'b1;
              end
            end
          end else if (rollover) begin
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (rollover) begin
            tx_sr <= {1'b0, tx_sr[8:1]};
            if (tx_sr[8:1] == `USAM_TX_MARK) begin
              tx_state <= TX_IDLE;
              tx_set <= 1'b1;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  usam_vote u_vote (
    .samples(votes),
    .accepted(vote_bit)
  );

  // Shift-mode data sampled at S5 of each machine cycle
  always @(posedge ref_clk) begin
    if (reset) begin
      rx_sample <= 1'b1;
    end else if (mstate == `USAM_ST_S5) begin
      rx_sample <= data_sync;
    end
  end

  // Mode changes during a frame are not guarded against
  always @(posedge ref_clk) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_sr <= 9'h1FF;
      rx_first <= 1'b0;
      rx_last <= 1'b0;
      votes <= 3'h7;
      rx_buffer <= 8'h00;
      rx_ninth_bit <= 1'b0;
      rx_set <= 1'b0;
    end else begin
      rx_set <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_last <= 1'b0;
          if (!mode_async & rx_enable & !rx_done_flag) begin
            rx_state <= RX_ARM;
          end else if (rx_start) begin
            rx_sr <= `USAM_RX_PRE_ASYNC;
            rx_first <= 1'b1;
            rx_state <= RX_ASYNC;
          end
        end
        RX_ARM: begin
          if (at_s6) begin
            rx_sr[7:0] <= `USAM_RX_PRE_SHIFT;
            rx_state <= RX_RECV;
          end
        end
        RX_RECV: begin
          if (rx_last & at_s1) begin
            rx_state <= RX_IDLE;
            rx_set <= 1'b1;
          end else if (at_s6 & !rx_last) begin
            rx_sr[7:0] <= {rx_sr[6:0], rx_sample};
            if (!rx_sr[7]) begin
              rx_last <= 1'b1;
              rx_buffer <= bit_reverse({rx_sr[6:0], rx_sample});
            end
          end
        end
        RX_ASYNC: begin
          if (tick16 & (div16 == `USAM_VOTE_A)) begin
            votes[0] <= data_sync;
          end
          if (tick16 & (div16 == `USAM_VOTE_B)) begin
            votes[1] <= data_sync;
          end
          if (tick16 & (div16 == `USAM_VOTE_C)) begin
            votes[2] <= data_sync;
          end
          if (rollover) begin
            if (rx_first) begin
              rx_first <= 1'b0;
              if (vote_bit) begin
                rx_state <= RX_IDLE;
              end else begin
                rx_sr <= {rx_sr[7:0], vote_bit};
              end
            end else if (!rx_sr[8]) begin
              // Final rollover, no shift: the voted bit is the stop bit
              rx_state <= RX_IDLE;
              if (!rx_done_flag &
                  (!multiproc_qualify_bit | vote_bit)) begin
                rx_buffer <= bit_reverse(rx_sr[7:0]);
                rx_ninth_bit <= vote_bit;
                rx_set <= 1'b1;
              end
            end else begin
              rx_sr <= {rx_sr[7:0], vote_bit};
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Pins lag the internal state by one clock to stay registered
  always @* begin
    next_clock = 1'b1;
    next_data_out = 1'b1;
    next_data_oe = 1'b0;
    if (!mode_async) begin
      if ((tx_state == TX_SEND) | (rx_state == RX_RECV)) begin
        next_clock = ~((mstate == `USAM_ST_S3) |
                       (mstate == `USAM_ST_S4) |
                       (mstate == `USAM_ST_S5));
      end
      if (tx_state == TX_SEND) begin
        next_data_out = tx_sr[0];
        next_data_oe = 1'b1;
      end
    end else begin
      if (tx_state == TX_SEND) begin
        next_clock = 1'b0;
      end else if (tx_state == TX_DATA) begin
        next_clock = tx_sr[0];
      end
    end
  end

  // Output registers
  always @(posedge ref_clk) begin
    if (reset) begin
      shift_clock_line <= 1'b1;
      shift_data_line_out <= 1'b1;
      shift_data_line_oe <= 1'b0;
    end else begin
      shift_clock_line <= next_clock;
      shift_data_line_out <= next_data_out;
      shift_data_line_oe <= next_data_oe;
    end
  end

endmodule

// File: usam_map.vh
`ifndef USAM_MAP_VH
`define USAM_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define USAM_ADDR_DATA 12'h000
`define USAM_ADDR_CTRL 12'h004
`define USAM_ADDR_POWER 12'h008

// ----------------------------------------------------------------
// Control and power register fields
// ----------------------------------------------------------------
`define USAM_CTRL_RX_DONE 0
`define USAM_CTRL_TX_DONE 1
`define USAM_CTRL_NINTH 2
`define USAM_CTRL_RX_EN 4
`define USAM_CTRL_QUALIFY 5
`define USAM_CTRL_ASYNC 6
`define USAM_POWER_DOUBLE 0
`define USAM_BAUD_DOUBLE_RST 1'h0

// ----------------------------------------------------------------
// Machine-cycle states and counts
// ----------------------------------------------------------------
`define USAM_ST_S1 3'h0
`define USAM_ST_S3 3'h2
`define USAM_ST_S4 3'h3
`define USAM_ST_S5 3'h4
`define USAM_ST_S6 3'h5
`define USAM_DIV_LAST 4'hF
`define USAM_VOTE_A 4'h6
`define USAM_VOTE_B 4'h7
`define USAM_VOTE_C 4'h8
`define USAM_TX_MARK 8'h01
`define USAM_TX_LOAD 1'h1
`define USAM_RX_PRE_SHIFT 8'hFE
`define USAM_RX_PRE_ASYNC 9'h1FF

`endif

// File: usam_vote.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-of-three bit detector
// ----------------------------------------------------------------
module usam_vote (
  input wire [2:0] samples,
  output wire accepted
);

  // Majority rejects a single noisy sample
  assign accepted = (samples[0] & samples[1]) |
                    (samples[1] & samples[2]) |
                    (samples[0] & samples[2]);

endmodule

// File: usam_core_properties.sv
`timescale 1ns/1ps
`include "usam_map.vh"
module usam_core_properties (
  input wire ref_clk,
  input wire reset,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire timer1_overflow,
  input wire shift_clock_line,
  input wire shift_data_line_in,
  input wire shift_data_line_out,
  input wire shift_data_line_oe
);
  reg async_mode;
  reg [3:0] falls;
  wire ctl_wr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------
  // Mode mirror and bit counter
  // ----------------------------------------------------------
  // Mode is mirrored from bus writes; the core hides it
  assign ctl_wr = psel && penable && pready && pwrite &&
    (paddr == `USAM_ADDR_CTRL);
  always @(posedge ref_clk) begin
    if (reset) begin
      async_mode <= 1'b0;
      falls <= 4'h0;
    end else begin
      if (ctl_wr)
        async_mode <= pwdata[`USAM_CTRL_ASYNC];
      if (!shift_data_line_oe)
        falls <= 4'h0;
      else if ($fell(shift_clock_line))
        falls <= falls + 4'h1;
    end
  end
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_error_map: assert property (pready |->
    pslverr == (paddr > `USAM_ADDR_POWER))
    else $error("error flag does not match address");
  a_clock_shape: assert property (!async_mode &&
    $fell(shift_clock_line) |->
    !shift_clock_line [*3] ##1 shift_clock_line [*3])
    else $error("shift clock not three low three high");
  a_data_steady: assert property (shift_data_line_oe &&
    $past(shift_data_line_oe) && !shift_clock_line |->
    $stable(shift_data_line_out))
    else $error("data moved while clock low");
  a_eight_bits: assert property ($fell(shift_data_line_oe) |->
    falls == 4'h8)
    else $error("send phase did not hold eight bits");
  a_async_quiet: assert property (async_mode |->
    !shift_data_line_oe && shift_data_line_out)
    else $error("data line driven in async mode");
  a_reset_idle: assert property (disable iff (1'b0) reset |=>
    shift_clock_line && !shift_data_line_oe && !pready)
    else $error("outputs not idle after reset");
  c_send: cover property ($fell(shift_data_line_oe));
  c_error: cover property (pslverr);
  c_async_tx: cover property (async_mode && $fell(shift_clock_line));
endmodule
bind usam_core usam_core_properties u_props (.ref_clk(ref_clk),
  .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer1_overflow(timer1_overflow),
  .shift_clock_line(shift_clock_line),
  .shift_data_line_in(shift_data_line_in),
  .shift_data_line_out(shift_data_line_out),
  .shift_data_line_oe(shift_data_line_oe));

// File: usam_partner.sv
`timescale 1ns/1ps
module usam_partner (
  input wire ref_clk,
  input wire shift_clock_line,
  input wire data_line,
  input wire data_oe,
  output reg line_drive
);
  reg prev_clk = 1'b1;
  reg arm = 1'b0;
  reg [3:0] n_cap = 4'h0;
  reg [7:0] cap = 8'h00;
  reg [7:0] rx_byte = 8'h00;
  initial line_drive = 1'b1;
  // Shift side: take bits on the clock fall, move on at the rise;
  // once the byte is out the register rotates inverted bits
  always @(posedge ref_clk) begin
    prev_clk <= shift_clock_line;
    if (prev_clk && !shift_clock_line && data_oe && n_cap < 4'h8) begin
      cap[n_cap[2:0]] <= data_line;
      n_cap <= n_cap + 4'h1;
    end
    if (arm && !prev_clk && shift_clock_line) begin
      line_drive <= rx_byte[1];
      rx_byte <= {~rx_byte[0], rx_byte[7:1]};
    end
  end
  task arm_shift(input [7:0] b);
    begin
      rx_byte <= b;
      line_drive <= b[0];
      arm <= 1'b1;
      @(posedge ref_clk);
    end
  endtask
  // Remote sender: line idles high between frames
  task send(input [7:0] b, input stp, input integer bt);
    reg [9:0] f;
    integer i;
    begin
      f = {stp, b, 1'b0};
      arm <= 1'b0;
      for (i = 0; i < 10; i = i + 1) begin
        line_drive <= f[i];
        repeat (bt) @(posedge ref_clk);
      end
      // Idle a full bit so a low stop cannot hide the next start
      line_drive <= 1'b1;
      repeat (bt) @(posedge ref_clk);
    end
  endtask
  task glitch(input integer n);
    begin
      arm <= 1'b0;
      line_drive <= 1'b0;
      repeat (n) @(posedge ref_clk);
      line_drive <= 1'b1;
      repeat (400) @(posedge ref_clk);
    end
  endtask
  // Remote receiver: samples mid-bit on the transmit pin
  task recv(input integer bt, output [9:0] f);
    integer i;
    begin
      i = 0;
      while (shift_clock_line !== 1'b0 && i < 8000) begin
        @(posedge ref_clk);
        i = i + 1;
      end
      repeat (bt / 2) @(posedge ref_clk);
      for (i = 0; i < 10; i = i + 1) begin
        f[i] = shift_clock_line;
        repeat (bt) @(posedge ref_clk);
      end
    end
  endtask
endmodule

// File: uart_shift_and_async_modes_tb.sv
`timescale 1ns/1ps
`include "usam_map.vh"
module uart_shift_and_async_modes_tb;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg [11:0] paddr = 12'h000;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  reg timer1_overflow = 1'b0;
  reg [2:0] ovf_div = 3'h0;
  reg [31:0] rd;
  reg [9:0] fr;
  reg [7:0] b;
  reg err;
  integer fails = 0;
  integer n_compared = 0;
  integer j;
  wire [31:0] prdata;
  wire pready, pslverr, shift_clock_line, line_drive;
  wire shift_data_line_out, shift_data_line_oe;
  // Wire level: the core wins while it drives
  wire shift_data_line_in = shift_data_line_oe ? shift_data_line_out :
    line_drive;
  always #50 ref_clk = ~ref_clk;
  // Timer overflow every 800 ns
  always @(posedge ref_clk) begin
    ovf_div <= ovf_div + 3'h1;
    timer1_overflow <= (ovf_div == 3'h7);
  end
  usam_core DUT (.ref_clk(ref_clk), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_overflow(timer1_overflow),
    .shift_clock_line(shift_clock_line),
    .shift_data_line_in(shift_data_line_in),
    .shift_data_line_out(shift_data_line_out),
    .shift_data_line_oe(shift_data_line_oe));
  usam_partner PARTNER (.ref_clk(ref_clk),
    .shift_clock_line(shift_clock_line), .data_line(shift_data_line_in),
    .data_oe(shift_data_line_oe), .line_drive(line_drive));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task results;
    begin
      $display("Compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp, input [95:0] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Entered just after a clock edge; leaves one edge after release
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && i < 20) begin
        @(posedge ref_clk);
        i = i + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
      if (i == 20) begin
        fails = fails + 1;
        results;
      end
    end
  endtask
  task poll(input integer n);
    integer k;
    begin
      k = 0;
      rd = 32'h0;
      while (rd[n] !== 1'b1 && k < 1000) begin
        apb(1'b0, `USAM_ADDR_CTRL, 32'h0);
        k = k + 1;
      end
      if (k == 1000) begin
        fails = fails + 1;
        results;
      end
    end
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, `USAM_ADDR_CTRL, 32'h0);
    check(rd, 32'h0, "ctrl reset");
    apb(1'b0, `USAM_ADDR_POWER, 32'h0);
    check(rd, 32'h0, "power reset");
    apb(1'b1, 12'h00C, 32'h5);
    check(err, 1'b1, "unmapped wr");
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h0, "unmapped rd");
    // Shift sends, each with a write dropped while busy
    for (j = 0; j < 3; j = j + 1) begin
      b = (j == 0) ? 8'hA5 : (j == 1) ? 8'h80 : 8'h00;
      PARTNER.n_cap = 4'h0;
      apb(1'b1, `USAM_ADDR_DATA, {24'h0, b});
      repeat (20) @(posedge ref_clk);
      apb(1'b1, `USAM_ADDR_DATA, 32'h3C);
      apb(1'b0, `USAM_ADDR_CTRL, 32'h0);
      check(rd[`USAM_CTRL_TX_DONE], 1'b0, "early done");
      poll(`USAM_CTRL_TX_DONE);
      check(PARTNER.cap, b, "shift tx");
      apb(1'b1, `USAM_ADDR_CTRL, 32'h0);
    end
    // Shift receive, then stop receiving before the flag clears
    PARTNER.arm_shift(8'h96);
    apb(1'b1, `USAM_ADDR_CTRL, 32'h10);
    poll(`USAM_CTRL_RX_DONE);
    apb(1'b0, `USAM_ADDR_DATA, 32'h0);
    check(rd, 32'h96, "shift rx");
    apb(1'b1, `USAM_ADDR_CTRL, 32'h03);
    // Async send at the doubled rate
    PARTNER.send(8'hFF, 1'b1, 1);
    apb(1'b1, `USAM_ADDR_POWER, 32'h1);
    apb(1'b1, `USAM_ADDR_CTRL, 32'h50);
    fork
      apb(1'b1, `USAM_ADDR_DATA, 32'h5A);
      PARTNER.recv(128, fr);
    join
    check(fr, {1'b1, 8'h5A, 1'b0}, "async tx");
    poll(`USAM_CTRL_TX_DONE);
    apb(1'b1, `USAM_ADDR_CTRL, 32'h50);
    // False start, then a good frame
    PARTNER.glitch(16);
    PARTNER.send(8'hC3, 1'b1, 128);
    poll(`USAM_CTRL_RX_DONE);
    check(rd[`USAM_CTRL_NINTH], 1'b1, "stop bit");
    apb(1'b0, `USAM_ADDR_DATA, 32'h0);
    check(rd, 32'hC3, "async rx");
    // Flag still set: the frame is lost
    PARTNER.send(8'h11, 1'b1, 128);
    apb(1'b0, `USAM_ADDR_DATA, 32'h0);
    check(rd, 32'hC3, "kept");
    // Qualify on: bad stop dropped, good one taken
    apb(1'b1, `USAM_ADDR_CTRL, 32'h70);
    PARTNER.send(8'h22, 1'b0, 128);
    PARTNER.send(8'h77, 1'b1, 128);
    poll(`USAM_CTRL_RX_DONE);
    apb(1'b0, `USAM_ADDR_DATA, 32'h0);
    check(rd, 32'h77, "qualify");
    // Normal rate halves the bit clock
    apb(1'b1, `USAM_ADDR_POWER, 32'h0);
    apb(1'b1, `USAM_ADDR_CTRL, 32'h50);
    PARTNER.send(8'h81, 1'b1, 256);
    poll(`USAM_CTRL_RX_DONE);
    apb(1'b0, `USAM_ADDR_DATA, 32'h0);
    check(rd, 32'h81, "slow rx");
    results;
  end
endmodule
